// >>> design/timer16_capture.sv
// 16-bit up/down timer counter with input capture on an 8-bit I/O bus.
//
// What this block does
// - Clock source zero keeps the counter stopped.
// - Each timer tick clears, increments or decrements.
// - Flag top and bottom of the count.
// - High byte locations access the holding register.
// - Low byte access moves high byte through holding.
// - Counter accessible whether or not ticking.
// - Processor write beats any count operation.
// - Four-bit waveform mode sets counting sequence.
// - Overflow flag set per mode, requests interrupt.
// - Accepted capture edge copies counter into capture.
// - Capture flag sets with the copy.
// - Capture flag interrupts, clears on service or write.
// - Capture low read first fills holding register.
// - Capture writable only in capture-top modes.
// - Comparator select bit switches capture source.
// - Capture inputs sampled like external clock pin.
// - Filter and edge idle in capture-top modes.
// - Port-driven capture pin triggers like external.
// - Filter output changes after four agreeing samples.
// - Filter on system clock, four cycles delay.
// - Top is fixed, compare A or capture.
// - Flags visible and individually maskable.
`timescale 1ns/1ps

module timer16_capture (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire timer16_pkg::ctrl_t    ctrl,
    input  wire logic [3:0]            prescale_tick,
    input  wire logic                  ext_count_pin,
    input  wire logic                  capture_pin,
    input  wire logic                  comparator_output,
    input  wire logic [15:0]           compare_a_register,
    input  wire timer16_pkg::io_req_t  io_req,
    input  wire timer16_pkg::flag_evt_t flag_clear,
    input  wire timer16_pkg::flag_evt_t irq_ack,
    output logic [7:0]                 io_rdata,
    output logic [15:0]                count_value,
    output logic                       capture_flag,
    output logic                       overflow_flag,
    output logic                       irq_capture,
    output logic                       irq_overflow,
    output logic                       at_top,
    output logic                       at_bottom
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (timer16_pkg::FILTER_SAMPLES != 4 || timer16_pkg::CNT_W != 16) begin
        $error("Filter must hold four samples and counter 16 bits.");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0]          rst_sync_q;
    logic                rst_n;
    timer16_pkg::state_t s_q;
    timer16_pkg::state_t s_d;
    logic [15:0]         top;
    logic                icr_top;
    logic                dual_slope;
    logic                fast_mode;
    logic                tick;
    logic                filtered;
    logic                cap_event;
    logic                ovf_event;
    logic                wr_cnt_low;
    logic                wr_cap_low;
    logic                rd_cnt_low;
    logic                rd_cap_low;
    logic                rd_high;
    logic                wr_high;

    // Release the asynchronous reset through two flops so it leaves cleanly.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // Mode decode and top value
    // ------------------------------------------------------------------
    // Modes using the capture register as top turn the capture path off.
    always_comb begin
        icr_top    = ctrl.waveform_mode_field inside {
            timer16_pkg::WGM_PFC_ICR, timer16_pkg::WGM_PC_ICR,
            timer16_pkg::WGM_CTC_ICR, timer16_pkg::WGM_FAST_ICR};
        dual_slope = ctrl.waveform_mode_field inside {
            timer16_pkg::WGM_PC_8, timer16_pkg::WGM_PC_9,
            timer16_pkg::WGM_PC_10, timer16_pkg::WGM_PFC_ICR,
            timer16_pkg::WGM_PFC_OCR, timer16_pkg::WGM_PC_ICR,
            timer16_pkg::WGM_PC_OCR};
        fast_mode  = ctrl.waveform_mode_field inside {
            timer16_pkg::WGM_FAST_8, timer16_pkg::WGM_FAST_9,
            timer16_pkg::WGM_FAST_10, timer16_pkg::WGM_FAST_ICR,
            timer16_pkg::WGM_FAST_OCR};
        // Normal mode and the unused code run to the full 16-bit maximum.
        unique case (ctrl.waveform_mode_field)
            timer16_pkg::WGM_PC_8,
            timer16_pkg::WGM_FAST_8:   top = timer16_pkg::TOP_8BIT;
            timer16_pkg::WGM_PC_9,
            timer16_pkg::WGM_FAST_9:   top = timer16_pkg::TOP_9BIT;
            timer16_pkg::WGM_PC_10,
            timer16_pkg::WGM_FAST_10:  top = timer16_pkg::TOP_10BIT;
            timer16_pkg::WGM_CTC_OCR,
            timer16_pkg::WGM_PFC_OCR,
            timer16_pkg::WGM_PC_OCR,
            timer16_pkg::WGM_FAST_OCR: top = compare_a_register;
            timer16_pkg::WGM_PFC_ICR,
            timer16_pkg::WGM_PC_ICR,
            timer16_pkg::WGM_CTC_ICR,
            timer16_pkg::WGM_FAST_ICR: top = s_q.icr;
            default:                   top = timer16_pkg::CNT_MAX;
        endcase
    end

    // ------------------------------------------------------------------
    // Timer tick selection
    // ------------------------------------------------------------------
    // The external pin is sampled once and edge-detected on the system clock.
    always_comb begin
        unique case (ctrl.clock_source_field)
            timer16_pkg::CS_STOP:     tick = 1'b0;
            timer16_pkg::CS_DIV1:     tick = 1'b1;
            timer16_pkg::CS_DIV8:     tick = prescale_tick[0];
            timer16_pkg::CS_DIV64:    tick = prescale_tick[1];
            timer16_pkg::CS_DIV256:   tick = prescale_tick[2];
            timer16_pkg::CS_DIV1024:  tick = prescale_tick[3];
            timer16_pkg::CS_EXT_FALL: tick = s_q.ext_prev & ~s_q.ext_smp;
            timer16_pkg::CS_EXT_RISE: tick = ~s_q.ext_prev & s_q.ext_smp;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus decode and event terms
    // ------------------------------------------------------------------
    assign wr_cnt_low = io_req.wr && io_req.addr == timer16_pkg::ADDR_CNT_LOW;
    assign wr_cap_low = io_req.wr && io_req.addr == timer16_pkg::ADDR_CAP_LOW;
    assign rd_cnt_low = io_req.rd && io_req.addr == timer16_pkg::ADDR_CNT_LOW;
    assign rd_cap_low = io_req.rd && io_req.addr == timer16_pkg::ADDR_CAP_LOW;
    assign rd_high    = io_req.rd && io_req.addr[0];
    assign wr_high    = io_req.wr && io_req.addr[0];

    // Filter output or raw sample feeds the edge detector.
    assign filtered  = ctrl.noise_filter_enable ? s_q.filt_out : s_q.cap_smp;
    assign cap_event = !icr_top && (filtered != s_q.edge_prev)
                       && (filtered == ctrl.capture_edge_rising);
    assign ovf_event = tick && (dual_slope ?
        (s_q.cnt == timer16_pkg::CNT_BOTTOM && !s_q.dir_up) :
        (fast_mode ? s_q.cnt == top : s_q.cnt == timer16_pkg::CNT_MAX));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Later assignments override earlier ones, which sets the priorities.
    always_comb begin
        s_d = s_q;
        // Pins see one sampling stage; the port-driven pin level counts too.
        s_d.ext_smp  = ext_count_pin;
        s_d.ext_prev = s_q.ext_smp;
        s_d.cap_smp  = ctrl.comparator_capture_select ?
                       comparator_output : capture_pin;
        // Filter and edge memory freeze while capture defines top.
        if (!icr_top) begin
            // Shift in the fresh sample, so the filter costs four cycles.
            s_d.filt_sh   = {s_q.filt_sh[2:0], s_d.cap_smp};
            if (&s_q.filt_sh) begin
                s_d.filt_out = 1'b1;
            end else if (~|s_q.filt_sh) begin
                s_d.filt_out = 1'b0;
            end
            s_d.edge_prev = filtered;
        end
        // Counting on the selected timer tick.
        if (tick) begin
            if (dual_slope) begin
                if (s_q.dir_up && s_q.cnt >= top) begin
                    s_d.dir_up = 1'b0;
                    s_d.cnt    = s_q.cnt - 16'h0001;
                end else if (!s_q.dir_up
                             && s_q.cnt == timer16_pkg::CNT_BOTTOM) begin
                    s_d.dir_up = 1'b1;
                    s_d.cnt    = s_q.cnt + 16'h0001;
                end else if (s_q.dir_up) begin
                    s_d.cnt    = s_q.cnt + 16'h0001;
                end else begin
                    s_d.cnt    = s_q.cnt - 16'h0001;
                end
            end else if (s_q.cnt == top) begin
                s_d.cnt    = timer16_pkg::CNT_BOTTOM;
                s_d.dir_up = 1'b1;
            end else begin
                s_d.cnt    = s_q.cnt + 16'h0001;
                s_d.dir_up = 1'b1;
            end
        end
        // High byte locations only ever touch the holding register.
        if (wr_high) begin
            s_d.temp = io_req.wdata;
        end
        if (rd_high) begin
            s_d.rdata = s_q.temp;
        end
        if (rd_cnt_low) begin
            s_d.temp  = s_q.cnt[15:8];
            s_d.rdata = s_q.cnt[7:0];
        end
        if (rd_cap_low) begin
            s_d.temp  = s_q.icr[15:8];
            s_d.rdata = s_q.icr[7:0];
        end
        // A processor write beats the count in the same cycle.
        if (wr_cnt_low) begin
            s_d.cnt = {s_q.temp, io_req.wdata};
        end
        // Capture register: hardware copy, or software load in top modes.
        if (cap_event) begin
            s_d.icr = s_q.cnt;
        end else if (wr_cap_low && icr_top) begin
            s_d.icr = {s_q.temp, io_req.wdata};
        end
        // Hardware set wins over a clear arriving in the same cycle.
        s_d.cap_flag = cap_event
            || (s_q.cap_flag && !(flag_clear.capture || irq_ack.capture));
        s_d.ovf_flag = ovf_event
            || (s_q.ovf_flag && !(flag_clear.overflow || irq_ack.overflow));
        s_d.irq_cap   = s_d.cap_flag && ctrl.capture_irq_enable;
        s_d.irq_ovf   = s_d.ovf_flag && ctrl.overflow_irq_enable;
        s_d.at_top    = s_d.cnt == top;
        s_d.at_bottom = s_d.cnt == timer16_pkg::CNT_BOTTOM;
    end

    // All state but the two reset release flops sits in one register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= timer16_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign io_rdata      = s_q.rdata;
    assign count_value   = s_q.cnt;
    assign capture_flag  = s_q.cap_flag;
    assign overflow_flag = s_q.ovf_flag;
    assign irq_capture   = s_q.irq_cap;
    assign irq_overflow  = s_q.irq_ovf;
    assign at_top        = s_q.at_top;
    assign at_bottom     = s_q.at_bottom;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_stop_holds: assert property (
        ctrl.clock_source_field == timer16_pkg::CS_STOP && !wr_cnt_low
        |=> $stable(s_q.cnt))
        else $error("Counter moved with no clock source.");
    a_write_wins: assert property (
        wr_cnt_low |=> s_q.cnt == {$past(s_q.temp), $past(io_req.wdata)})
        else $error("Counter write lost to counting.");
    a_low_read_temp: assert property (
        rd_cnt_low && !wr_high |=> s_q.temp == $past(s_q.cnt[15:8]))
        else $error("Counter low read did not fill holding byte.");
    a_high_read_temp: assert property (
        rd_high && !rd_cnt_low && !rd_cap_low
        |=> io_rdata == $past(s_q.temp))
        else $error("High byte read did not return holding byte.");
    a_capture_copy: assert property (
        cap_event |=> s_q.icr == $past(s_q.cnt) && capture_flag)
        else $error("Capture did not copy counter and set flag.");
    a_capture_irq: assert property (
        capture_flag && ctrl.capture_irq_enable && !flag_clear.capture
        && !irq_ack.capture |=> irq_capture)
        else $error("Enabled capture flag gave no interrupt.");
    a_icr_guard: assert property (
        wr_cap_low && !icr_top && !cap_event |=> $stable(s_q.icr))
        else $error("Capture register written outside top modes.");
    a_filter_agree: assert property (
        !icr_top && !(&s_q.filt_sh) && |s_q.filt_sh
        |=> $stable(s_q.filt_out))
        else $error("Filter changed without four agreeing samples.");
    a_no_capture_top: assert property (
        icr_top && !wr_cap_low |=> $stable(s_q.icr))
        else $error("Capture register moved in a capture-top mode.");
    a_ovf_sets: assert property (
        ovf_event |=> overflow_flag
        && irq_overflow == $past(ctrl.overflow_irq_enable))
        else $error("Overflow event did not set the flag.");

    c_capture:   cover property (cap_event ##1 irq_capture);
    c_overflow:  cover property (ovf_event);
    c_turn_down: cover property (tick && dual_slope && s_q.dir_up
                                 ##1 !s_q.dir_up);
    c_cnt_write: cover property (wr_high ##1 wr_cnt_low);

endmodule

// >>> design/timer16_pkg.sv
// Constants and types shared by the 16-bit timer with input capture.
package timer16_pkg;

    // ------------------------------------------------------------------
    // Widths, I/O locations and fixed counter values
    // ------------------------------------------------------------------
    localparam int          CNT_W          = 16;
    localparam int          BYTE_W         = 8;
    localparam int          FILTER_SAMPLES = 4;
    localparam logic [1:0]  ADDR_CNT_LOW   = 2'h0;
    localparam logic [1:0]  ADDR_CNT_HIGH  = 2'h1;
    localparam logic [1:0]  ADDR_CAP_LOW   = 2'h2;
    localparam logic [1:0]  ADDR_CAP_HIGH  = 2'h3;
    localparam logic [15:0] TOP_8BIT       = 16'h00ff;
    localparam logic [15:0] TOP_9BIT       = 16'h01ff;
    localparam logic [15:0] TOP_10BIT      = 16'h03ff;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM     = 16'h0000;

    // ------------------------------------------------------------------
    // Clock source codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  CS_STOP        = 3'h0;
    localparam logic [2:0]  CS_DIV1        = 3'h1;
    localparam logic [2:0]  CS_DIV8        = 3'h2;
    localparam logic [2:0]  CS_DIV64       = 3'h3;
    localparam logic [2:0]  CS_DIV256      = 3'h4;
    localparam logic [2:0]  CS_DIV1024     = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL    = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE    = 3'h7;

    // ------------------------------------------------------------------
    // Waveform mode codes
    // ------------------------------------------------------------------
    localparam logic [3:0]  WGM_NORMAL     = 4'h0;
    localparam logic [3:0]  WGM_PC_8       = 4'h1;
    localparam logic [3:0]  WGM_PC_9       = 4'h2;
    localparam logic [3:0]  WGM_PC_10      = 4'h3;
    localparam logic [3:0]  WGM_CTC_OCR    = 4'h4;
    localparam logic [3:0]  WGM_FAST_8     = 4'h5;
    localparam logic [3:0]  WGM_FAST_9     = 4'h6;
    localparam logic [3:0]  WGM_FAST_10    = 4'h7;
    localparam logic [3:0]  WGM_PFC_ICR    = 4'h8;
    localparam logic [3:0]  WGM_PFC_OCR    = 4'h9;
    localparam logic [3:0]  WGM_PC_ICR     = 4'ha;
    localparam logic [3:0]  WGM_PC_OCR     = 4'hb;
    localparam logic [3:0]  WGM_CTC_ICR    = 4'hc;
    localparam logic [3:0]  WGM_FAST_ICR   = 4'he;
    localparam logic [3:0]  WGM_FAST_OCR   = 4'hf;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] clock_source_field;
        logic [3:0] waveform_mode_field;
        logic       noise_filter_enable;
        logic       capture_edge_rising;
        logic       comparator_capture_select;
        logic       capture_irq_enable;
        logic       overflow_irq_enable;
    } ctrl_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic capture;
        logic overflow;
    } flag_evt_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        dir_up;
        logic [7:0]  temp;
        logic [15:0] icr;
        logic        cap_flag;
        logic        ovf_flag;
        logic        ext_smp;
        logic        ext_prev;
        logic        cap_smp;
        logic [3:0]  filt_sh;
        logic        filt_out;
        logic        edge_prev;
        logic [7:0]  rdata;
        logic        at_top;
        logic        at_bottom;
        logic        irq_cap;
        logic        irq_ovf;
    } state_t;

    localparam state_t STATE_RESET = '{dir_up: 1'b1, default: '0};

endpackage

// >>> verif/cpu_io_model.sv
// Processor-side model that issues byte accesses on the timer I/O bus.
`timescale 1ns/1ps
module cpu_io_model (
    input  wire logic              clk,
    output timer16_pkg::io_req_t   io_req,
    output timer16_pkg::flag_evt_t flag_clear,
    output timer16_pkg::flag_evt_t irq_ack
);
    // -----------------------------------------------------------------
    // Bus strobes
    // -----------------------------------------------------------------
    // Everything moves on the falling edge, clear of the sampling edge.
    initial begin
        io_req = '0;
        flag_clear = '0;
        irq_ack = '0;
    end
    task automatic acc(input logic r, w, input logic [1:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        io_req <= '{rd: r, wr: w, addr: a, wdata: d};
    endtask
    // Released data is inverted so a stale byte can never look valid.
    task automatic idle();
        @(negedge clk);
        io_req.rd <= 1'b0;
        io_req.wr <= 1'b0;
        io_req.wdata <= ~io_req.wdata;
    endtask
    // Upper byte goes to the holding byte first; the low byte commits.
    task automatic wr16(input logic [1:0] lo, input logic [15:0] v);
        acc(1'b0, 1'b1, lo + 2'h1, v[15:8]);
        acc(1'b0, 1'b1, lo, v[7:0]);
        idle();
    endtask
    // Low byte is read first so the upper byte is frozen for the pair.
    task automatic rd16(input logic [1:0] lo);
        acc(1'b1, 1'b0, lo, 8'h00);
        acc(1'b1, 1'b0, lo + 2'h1, 8'h00);
        idle();
    endtask
    task automatic pulse(input timer16_pkg::flag_evt_t c, k);
        @(negedge clk);
        flag_clear <= c;
        irq_ack <= k;
        @(negedge clk);
        flag_clear <= '0;
        irq_ack <= '0;
    endtask
endmodule

// >>> verif/test_counter16_with_input_capture.sv
// Self-checking bench for the 16-bit timer with input capture.
`timescale 1ns/1ps
module test_counter16_with_input_capture;
    logic                   clk = 1'b0;
    logic                   arst_n = 1'b0;
    timer16_pkg::ctrl_t     ctrl = '0;
    timer16_pkg::io_req_t   io_req;
    timer16_pkg::flag_evt_t flag_clear, irq_ack;
    logic                   cap_pin = 1'b0, cmp_out = 1'b0, rd_q = 1'b0;
    logic                   ext_pin = 1'b0;
    logic [7:0]             io_rdata;
    logic [15:0]            count_value, v;
    logic                   capture_flag, overflow_flag, irq_capture;
    logic                   irq_overflow, at_top, at_bottom;
    logic [7:0]             exp_q[$];
    logic [31:0]            seed = 32'hbd73;
    int                     mismatches = 0, checked = 0, n, lat[3];

    always #5 clk = ~clk;

    timer16_capture u_dut (.clk(clk), .arst_n(arst_n), .ctrl(ctrl),
        .prescale_tick(4'h0), .ext_count_pin(ext_pin), .capture_pin(cap_pin),
        .comparator_output(cmp_out), .compare_a_register(16'h0400),
        .io_req(io_req), .flag_clear(flag_clear), .irq_ack(irq_ack),
        .io_rdata(io_rdata), .count_value(count_value),
        .capture_flag(capture_flag), .overflow_flag(overflow_flag),
        .irq_capture(irq_capture), .irq_overflow(irq_overflow),
        .at_top(at_top), .at_bottom(at_bottom));
    cpu_io_model u_cpu (.clk(clk), .io_req(io_req),
        .flag_clear(flag_clear), .irq_ack(irq_ack));

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // A bound that runs out is a failure and ends the run at once.
    task automatic wait_for(input logic [15:0] val, input int sel);
        n = 0;
        while ((sel == 0 ? capture_flag : sel == 1 ? overflow_flag :
               count_value == val) !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic read16(input logic [1:0] lo, input logic [15:0] e);
        exp_q.push_back(e[7:0]);
        exp_q.push_back(e[15:8]);
        u_cpu.rd16(lo);
        @(negedge clk);
    endtask

    // Read data stands from the taking edge; pop and compare on the next falling edge.
    always @(posedge clk) rd_q <= io_req.rd;
    always @(negedge clk) begin
        if (rd_q === 1'b1) begin
            if (exp_q.size() == 0) chk({8'h00, io_rdata}, 16'hdead);
            else chk({8'h00, io_rdata}, {8'h00, exp_q.pop_front()});
        end
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (24) @(negedge clk);
        chk(count_value, 16'h0000);
        seed = xs(seed);
        v = seed[15:0];
        u_cpu.wr16(timer16_pkg::ADDR_CNT_LOW, v);
        read16(timer16_pkg::ADDR_CNT_LOW, v);
        ctrl.clock_source_field = timer16_pkg::CS_DIV1;
        v = count_value;
        @(negedge clk);
        chk(count_value, v + 16'h0001);
        u_cpu.wr16(timer16_pkg::ADDR_CNT_LOW, 16'hfff0);
        chk(count_value, 16'hfff0);
        wait_for(16'h0, 1);
        chk(count_value, timer16_pkg::CNT_BOTTOM);
        chk({15'h0, at_bottom}, 16'h0001);
        chk({15'h0, irq_overflow}, 16'h0000);
        u_cpu.pulse(2'b01, 2'b00);
        chk({15'h0, overflow_flag}, 16'h0000);
        ctrl.waveform_mode_field = timer16_pkg::WGM_FAST_8;
        ctrl.overflow_irq_enable = 1'b1;
        wait_for(timer16_pkg::TOP_8BIT, 2);
        chk({15'h0, at_top}, 16'h0001);
        @(negedge clk);
        chk(count_value, 16'h0000);
        chk({15'h0, overflow_flag}, 16'h0001);
        chk({15'h0, irq_overflow}, 16'h0001);
        // Dual slope turns at the fixed top and comes back down.
        ctrl.waveform_mode_field = timer16_pkg::WGM_PC_8;
        u_cpu.wr16(timer16_pkg::ADDR_CNT_LOW, 16'h00fd);
        repeat (4) @(negedge clk);
        chk(count_value, 16'h00fd);
        // Each rising edge on the count pin advances the counter once.
        ctrl = '{clock_source_field: timer16_pkg::CS_EXT_RISE, default: '0};
        v = count_value;
        repeat (3) begin
            ext_pin = 1'b1;
            repeat (2) @(negedge clk);
            ext_pin = 1'b0;
            repeat (2) @(negedge clk);
        end
        chk(count_value, v + 16'h0003);
        ctrl = '0;
        // Counter is stopped so the captured value is known exactly.
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            v = seed[15:0];
            u_cpu.wr16(timer16_pkg::ADDR_CNT_LOW, v);
            ctrl.noise_filter_enable = (i == 1);
            ctrl.capture_edge_rising = (i != 2);
            ctrl.comparator_capture_select = (i == 2);
            ctrl.capture_irq_enable = (i == 0);
            cap_pin = 1'b0;
            cmp_out = 1'b1;
            repeat (10) @(negedge clk);
            u_cpu.pulse(2'b10, 2'b00);
            if (i == 2) cmp_out = 1'b0;
            else cap_pin = 1'b1;
            wait_for(16'h0, 0);
            lat[i] = n;
            chk({15'h0, irq_capture}, {15'h0, i == 0});
            read16(timer16_pkg::ADDR_CAP_LOW, v);
            u_cpu.pulse(2'b00, 2'b10);
            chk({15'h0, capture_flag}, 16'h0000);
        end
        chk(lat[1][15:0], lat[0][15:0] + 16'h4);
        // A three-sample pulse must not pass the filter.
        ctrl = '{noise_filter_enable: 1'b1, capture_edge_rising: 1'b1,
                 default: '0};
        cap_pin = 1'b0;
        repeat (8) @(negedge clk);
        u_cpu.pulse(2'b10, 2'b00);
        cap_pin = 1'b1;
        repeat (3) @(negedge clk);
        cap_pin = 1'b0;
        repeat (12) @(negedge clk);
        chk({15'h0, capture_flag}, 16'h0000);
        u_cpu.wr16(timer16_pkg::ADDR_CAP_LOW, 16'h1234);
        read16(timer16_pkg::ADDR_CAP_LOW, v);
        ctrl.waveform_mode_field = timer16_pkg::WGM_CTC_ICR;
        u_cpu.wr16(timer16_pkg::ADDR_CAP_LOW, 16'h1234);
        read16(timer16_pkg::ADDR_CAP_LOW, 16'h1234);
        cap_pin = 1'b1;
        repeat (12) @(negedge clk);
        chk({15'h0, capture_flag}, 16'h0000);
        close_out();
    end
endmodule
